// File: rtl/sepm_master.v
`timescale 1ns/100ps
`include "sepm_regs.vh"

module sepm_master #(
	parameter [`SEPM_TICK_W-1:0] TICK_CYCLES   = `SEPM_TICK_CYC,
	parameter [`SEPM_TO_W-1:0]   TIMEOUT_TICKS = `SEPM_TIMEOUT_TICKS
) (
	input  wire                   clk_in,
	input  wire                   resetn_in,
	input  wire                   start_in,
	input  wire                   dev_sel_in,
	input  wire [`SEPM_LEN_W-1:0] len_in,
	input  wire                   tx_valid_in,
	input  wire [7:0]             tx_data_in,
	input  wire                   master_serial_in,
	output reg                    sck_out,
	output reg                    master_serial_out,
	output reg  [1:0]             cs_n_out,
	output reg                    busy_out,
	output reg                    tx_take_out,
	output reg  [`SEPM_LEN_W-1:0] tx_index_out,
	output reg                    rx_valid_out,
	output reg  [7:0]             rx_data_out,
	output reg  [`SEPM_LEN_W-1:0] rx_index_out,
	output reg                    done_out,
	output reg                    timeout_out
);

	// ***********************************************************
	// states and local constants
	// ***********************************************************
	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_SETUP = 3'h1;
	localparam [2:0] ST_LOAD  = 3'h2;
	localparam [2:0] ST_LOW   = 3'h3;
	localparam [2:0] ST_HIGH  = 3'h4;
	localparam [2:0] ST_HOLD  = 3'h5;

	// counts arrive as plain integers; cut them to counter width
	localparam integer GUARD_I = `SEPM_GUARD_CYC - 1;
	localparam integer HALF_I  = `SEPM_HALF_CYC - 1;
	localparam [`SEPM_CNT_W-1:0] GUARD_END = GUARD_I[`SEPM_CNT_W-1:0];
	localparam [`SEPM_CNT_W-1:0] HALF_END  = HALF_I[`SEPM_CNT_W-1:0];
	localparam [`SEPM_TICK_W-1:0] TICK_END =
		TICK_CYCLES - {{(`SEPM_TICK_W-1){1'b0}}, 1'b1};

	// ***********************************************************
	// state registers
	// ***********************************************************
	reg [2:0]              state_q;
	reg [`SEPM_CNT_W-1:0]  cnt_q;
	reg [2:0]              bit_q;
	reg [7:0]              tx_sh_q;
	reg [7:0]              rx_sh_q;
	reg [`SEPM_LEN_W-1:0]  left_q;
	reg [`SEPM_TICK_W-1:0] tick_cnt_q;
	reg [`SEPM_TO_W-1:0]   to_cnt_q;
	reg                    err_q;
	reg                    miso_m_q;
	reg                    miso_s_q;

	wire tick_w;
	wire cnt_end_guard_w;
	wire cnt_end_half_w;
	wire last_byte_w;
	wire start_ok_w;
	wire byte_next_w;

	// index step shared by both byte counters
	function [`SEPM_LEN_W-1:0] next_idx;
		input [`SEPM_LEN_W-1:0] idx;
		begin
			next_idx = idx + {{(`SEPM_LEN_W-1){1'b0}}, 1'b1};
		end
	endfunction

	// count step down for the bytes still to go
	function [`SEPM_LEN_W-1:0] prev_idx;
		input [`SEPM_LEN_W-1:0] idx;
		begin
			prev_idx = idx - {{(`SEPM_LEN_W-1){1'b0}}, 1'b1};
		end
	endfunction

	// select pattern: only the chosen line goes low
	function [1:0] sel_pattern;
		input dev;
		begin
			sel_pattern = dev ? 2'h1 : 2'h2;
		end
	endfunction

	assign tick_w          = (tick_cnt_q == TICK_END);
	assign cnt_end_guard_w = (cnt_q == GUARD_END);
	assign cnt_end_half_w  = (cnt_q == HALF_END);
	assign last_byte_w     = (left_q == {`SEPM_LEN_W{1'b0}});
	// a start is taken only when idle and for a non-empty frame
	assign start_ok_w      = (state_q == ST_IDLE) && start_in &&
		(len_in != {`SEPM_LEN_W{1'b0}});
	// end of the high half after the eighth bit: next byte is due
	assign byte_next_w     = (state_q == ST_HIGH) && cnt_end_half_w &&
		(bit_q == 3'h0);

	// ***********************************************************
	// data-in synchroniser
	// ***********************************************************
	// pin is asynchronous; only the second stage is used
	// two stages cost two cycles, so the slave must settle
	// its bit well before each rising edge of the serial clock
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			miso_m_q <= 1'b1;
			miso_s_q <= 1'b1;
		end else begin
			miso_m_q <= master_serial_in;
			miso_s_q <= miso_m_q;
		end
	end

	// ***********************************************************
	// millisecond tick and stall timeout
	// ***********************************************************
	// ms tick counter
	// tick only runs inside a transfer, so each transfer starts fresh, not each wait
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			tick_cnt_q <= {`SEPM_TICK_W{1'b0}};
		end else if (state_q == ST_IDLE || tick_w) begin
			tick_cnt_q <= {`SEPM_TICK_W{1'b0}};
		end else begin
			tick_cnt_q <= tick_cnt_q + {{(`SEPM_TICK_W-1){1'b0}}, 1'b1};
		end
	end

	// stall timeout count
	// counts ticks only while waiting for a source byte
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			to_cnt_q <= {`SEPM_TO_W{1'b0}};
		end else if (state_q != ST_LOAD || tx_valid_in) begin
			to_cnt_q <= {`SEPM_TO_W{1'b0}};
		end else if (tick_w) begin
			to_cnt_q <= to_cnt_q + {{(`SEPM_TO_W-1){1'b0}}, 1'b1};
		end
	end

	// ***********************************************************
	// byte counters
	// ***********************************************************
	// indices from zero
	// both indices step together, so sent and received bytes pair up
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			left_q       <= {`SEPM_LEN_W{1'b0}};
			tx_index_out <= {`SEPM_LEN_W{1'b0}};
			rx_index_out <= {`SEPM_LEN_W{1'b0}};
		end else if (start_ok_w) begin
			left_q       <= prev_idx(len_in);
			tx_index_out <= {`SEPM_LEN_W{1'b0}};
			rx_index_out <= {`SEPM_LEN_W{1'b0}};
		end else if (byte_next_w) begin
			left_q       <= prev_idx(left_q);
			tx_index_out <= next_idx(tx_index_out);
			rx_index_out <= next_idx(rx_index_out);
		end
	end

	// ***********************************************************
	// transfer sequencer
	// ***********************************************************
	// one process holds every pin so edges and data stay aligned
	always @(posedge clk_in) begin
		if (!resetn_in) begin
			state_q           <= ST_IDLE;
			cnt_q             <= {`SEPM_CNT_W{1'b0}};
			bit_q             <= 3'h7;
			tx_sh_q           <= 8'h00;
			rx_sh_q           <= 8'h00;
			err_q             <= 1'b0;
			sck_out           <= 1'b1;
			master_serial_out <= 1'b1;
			cs_n_out          <= `SEPM_CS_IDLE;
			busy_out          <= 1'b0;
			tx_take_out       <= 1'b0;
			rx_valid_out      <= 1'b0;
			rx_data_out       <= 8'h00;
			done_out          <= 1'b0;
			timeout_out       <= 1'b0;
		end else begin
			// pulses default low
			tx_take_out  <= 1'b0;
			rx_valid_out <= 1'b0;
			done_out     <= 1'b0;
			timeout_out  <= 1'b0;
			cnt_q        <= cnt_q + {{(`SEPM_CNT_W-1){1'b0}}, 1'b1};
			// idle: a start pulls one select low
			// setup: 1 us guard before any clock edge
			// load: wait for the source byte, then first fall
			// low/high: eight falls launch, eight rises sample
			// hold: 1 us guard after the last rise, then release
			case (state_q)
			ST_IDLE: begin
				sck_out  <= 1'b1;
				cs_n_out <= `SEPM_CS_IDLE;
				busy_out <= 1'b0;
				cnt_q    <= {`SEPM_CNT_W{1'b0}};
				// zero length is refused without any pin activity
				if (start_ok_w) begin
					cs_n_out     <= sel_pattern(dev_sel_in);
					err_q        <= 1'b0;
					busy_out     <= 1'b1;
					state_q      <= ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (cnt_end_guard_w) begin
					state_q <= ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (tx_valid_in) begin
					tx_sh_q           <= {tx_data_in[6:0], 1'b0};
					sck_out           <= 1'b0;
					master_serial_out <= tx_data_in[7];
					tx_take_out       <= 1'b1;
					bit_q             <= 3'h7;
					cnt_q             <= {`SEPM_CNT_W{1'b0}};
					state_q           <= ST_LOW;
				end else if (to_cnt_q == TIMEOUT_TICKS) begin
					// limitation: the first counted tick may come early,
					// so the stall limit lies between n-1 and n ticks
					// stalled source: end the frame cleanly
					err_q   <= 1'b1;
					cnt_q   <= {`SEPM_CNT_W{1'b0}};
					state_q <= ST_HOLD;
				end
			end
			ST_LOW: begin
				if (cnt_end_half_w) begin
					sck_out <= 1'b1;
					rx_sh_q <= {rx_sh_q[6:0], miso_s_q};
					cnt_q   <= {`SEPM_CNT_W{1'b0}};
					if (bit_q == 3'h0) begin
						rx_valid_out <= 1'b1;
						rx_data_out  <= {rx_sh_q[6:0], miso_s_q};
						if (last_byte_w) begin
							state_q <= ST_HOLD;
						end else begin
							state_q <= ST_HIGH;
						end
					end else begin
						state_q <= ST_HIGH;
					end
				end
			end
			ST_HIGH: begin
				if (cnt_end_half_w) begin
					cnt_q <= {`SEPM_CNT_W{1'b0}};
					if (bit_q == 3'h0) begin
						state_q <= ST_LOAD;
					end else begin
						sck_out           <= 1'b0;
						master_serial_out <= tx_sh_q[7];
						tx_sh_q           <= {tx_sh_q[6:0], 1'b0};
						bit_q             <= bit_q - 3'h1;
						state_q           <= ST_LOW;
					end
				end
			end
			ST_HOLD: begin
				sck_out <= 1'b1;
				if (cnt_end_guard_w) begin
					cs_n_out    <= `SEPM_CS_IDLE;
					busy_out    <= 1'b0;
					done_out    <= 1'b1;
					timeout_out <= err_q;
					state_q     <= ST_IDLE;
				end
			end
			default: begin
				sck_out  <= 1'b1;
				cs_n_out <= `SEPM_CS_IDLE;
				busy_out <= 1'b0;
				state_q  <= ST_IDLE;
			end
			endcase
		end
	end

endmodule

// File: common/sepm_regs.vh
`ifndef SEPM_REGS_VH
`define SEPM_REGS_VH

// ***************************************************************
// clock and timing
// ***************************************************************
`define SEPM_CLK_MHZ      100
`define SEPM_GUARD_NS     1000
// least time, rounded up to whole cycles
`define SEPM_GUARD_CYC    ((`SEPM_GUARD_NS * `SEPM_CLK_MHZ + 999) / 1000)
`define SEPM_TICK_US      1000
`define SEPM_TICK_CYC     (`SEPM_TICK_US * `SEPM_CLK_MHZ)
// serial clock half period in system cycles
`define SEPM_HALF_CYC     8
`define SEPM_TIMEOUT_TICKS 10

// ***************************************************************
// widths and idle levels
// ***************************************************************
`define SEPM_CNT_W        8
`define SEPM_TICK_W       17
`define SEPM_TO_W         8
`define SEPM_LEN_W        10
`define SEPM_DEVS         2
`define SEPM_CS_IDLE      2'h3

`endif

// File: tb/sepm_master_assertions.sv
`timescale 1ns/100ps
`include "sepm_regs.vh"
// ***
// pin checker
// ***
module sepm_master_checker (
	input wire                   clk_in,
	input wire                   resetn_in,
	input wire                   start_in,
	input wire                   dev_sel_in,
	input wire [`SEPM_LEN_W-1:0] len_in,
	input wire                   sck_out,
	input wire                   master_serial_out,
	input wire [1:0]             cs_n_out,
	input wire                   busy_out,
	input wire                   tx_take_out,
	input wire                   rx_valid_out,
	input wire                   done_out
);
	reg [7:0] hi_q;
	// saturating count of high sck cycles, bounds the hold wait
	always @(posedge clk_in) begin
		if (!resetn_in || !sck_out)
			hi_q <= 8'h00;
		else if (hi_q != 8'hFF)
			hi_q <= hi_q + 8'h01;
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	sequence s_go; start_in && !busy_out && (|len_in); endsequence
	sequence s_sel;
		busy_out && cs_n_out == ($past(dev_sel_in) ? 2'h1 : 2'h2);
	endsequence
	sequence s_low; !sck_out [*7] ##1 sck_out; endsequence
	property p_start; s_go |=> s_sel; endproperty
	property p_idle; !busy_out |-> sck_out && cs_n_out == 2'h3; endproperty
	property p_one; $countones(cs_n_out) >= 1; endproperty
	property p_half; $fell(sck_out) |=> s_low; endproperty
	property p_launch; $changed(master_serial_out) |-> $fell(sck_out); endproperty
	property p_sample; rx_valid_out |-> $rose(sck_out); endproperty
	property p_take; tx_take_out |-> $fell(sck_out) && busy_out; endproperty
	property p_setup;
		$fell(sck_out) |-> $past(cs_n_out, 100) != 2'h3 && cs_n_out != 2'h3;
	endproperty
	property p_hold; done_out |-> hi_q >= 8'h63 && cs_n_out == 2'h3; endproperty
	property p_done; (cs_n_out & ~$past(cs_n_out)) != 2'h0 |-> done_out;
	endproperty
	a_start: assert property (p_start) else $error("no select");
	a_idle: assert property (p_idle) else $error("idle pins");
	a_one: assert property (p_one) else $error("two selects");
	a_half: assert property (p_half) else $error("sck period");
	a_launch: assert property (p_launch) else $error("data edge");
	a_sample: assert property (p_sample) else $error("rx edge");
	a_take: assert property (p_take) else $error("take edge");
	a_setup: assert property (p_setup) else $error("setup");
	a_hold: assert property (p_hold) else $error("hold");
	a_done: assert property (p_done) else $error("release");
endmodule
bind sepm_master sepm_master_checker sepm_master_checker_i (
	.clk_in(clk_in), .resetn_in(resetn_in), .start_in(start_in),
	.dev_sel_in(dev_sel_in), .len_in(len_in), .sck_out(sck_out),
	.master_serial_out(master_serial_out), .cs_n_out(cs_n_out),
	.busy_out(busy_out), .tx_take_out(tx_take_out),
	.rx_valid_out(rx_valid_out), .done_out(done_out));

// File: tb/sepm_slave_model.sv
`timescale 1ns/100ps
// ***
// serial memory slave
// ***
module sepm_slave_model #(
	parameter [7:0] BASE = 8'h00
) (
	input  wire sck_in,
	input  wire cs_n_in,
	input  wire mosi_in,
	output reg  miso_out
);
	reg     [7:0] got [0:15];
	reg     [7:0] sh;
	reg     [7:0] cur;
	integer       ob;
	integer       ib;
	initial miso_out = 1'b0;
	always @(negedge cs_n_in) begin
		ob = 0;
		ib = 0;
	end
	// released line flips so a stale bit cannot pass
	always @(posedge cs_n_in) miso_out <= #12 ~miso_out;
	always @(negedge sck_in) begin
		if (!cs_n_in) begin
			cur = BASE + ob[10:3];
			miso_out <= #12 cur[7 - ob[2:0]];
			ob = ob + 1;
		end
	end
	always @(posedge sck_in) begin
		if (!cs_n_in) begin
			sh = {sh[6:0], mosi_in};
			ib = ib + 1;
			if (ib[2:0] == 3'h0)
				got[ib[6:3] - 1] = sh;
		end
	end
endmodule

// File: tb/sepm_master_test.sv
`timescale 1ns/100ps
// ***
// bench
// ***
module sepm_master_test;
	reg        clk_in, resetn_in, start_in, dev_sel_in, tx_valid_in, to;
	reg  [9:0] len_in;
	reg  [7:0] src_base, exp_base;
	wire [7:0] tx_data_in, rx_data_out;
	wire [9:0] tx_index_out, rx_index_out;
	wire [1:0] cs_n_out;
	wire       sck_out, mosi, busy_out, tx_take_out, rx_valid_out;
	wire       done_out, timeout_out, m0, m1;
	integer    err_count, check_count, rx_n;
	// source presents the byte for the asked index
	assign tx_data_in = src_base + tx_index_out[7:0];
	sepm_master #(.TICK_CYCLES(17'h00032), .TIMEOUT_TICKS(8'h02))
	sepm_master_i (.clk_in(clk_in), .resetn_in(resetn_in),
		.start_in(start_in), .dev_sel_in(dev_sel_in), .len_in(len_in),
		.tx_valid_in(tx_valid_in), .tx_data_in(tx_data_in),
		.master_serial_in(cs_n_out[1] ? m0 : m1), .sck_out(sck_out),
		.master_serial_out(mosi), .cs_n_out(cs_n_out),
		.busy_out(busy_out), .tx_take_out(tx_take_out),
		.tx_index_out(tx_index_out), .rx_valid_out(rx_valid_out),
		.rx_data_out(rx_data_out), .rx_index_out(rx_index_out),
		.done_out(done_out), .timeout_out(timeout_out));
	sepm_slave_model #(.BASE(8'h30)) s0 (.sck_in(sck_out),
		.cs_n_in(cs_n_out[0]), .mosi_in(mosi), .miso_out(m0));
	sepm_slave_model #(.BASE(8'h60)) s1 (.sck_in(sck_out),
		.cs_n_in(cs_n_out[1]), .mosi_in(mosi), .miso_out(m1));
	task chk(input [9:0] got, input [9:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task test_done;
		begin
			if (err_count == 0 && check_count > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	task run(input d, input [9:0] n, input v);
		integer k;
		begin
			dev_sel_in = d;
			len_in = n;
			tx_valid_in = v;
			exp_base = d ? 8'h60 : 8'h30;
			rx_n = 0;
			start_in = 1'b1;
			@(posedge clk_in) #1;
			start_in = 1'b0;
			for (k = 0; k < 6000 && done_out !== 1'b1; k = k + 1)
				@(posedge clk_in) #1;
			chk(done_out, 10'h001);
			to = timeout_out;
		end
	endtask
	task sent(input d, input [9:0] n);
		integer i;
		for (i = 0; i < n; i = i + 1)
			chk(d ? s1.got[i] : s0.got[i], src_base + i[7:0]);
	endtask
	always @(posedge clk_in) begin
		if (rx_valid_out === 1'b1) begin
			chk(rx_data_out, exp_base + rx_n[7:0]);
			chk(rx_index_out, rx_n[9:0]);
			rx_n = rx_n + 1;
		end
	end
	task t_frame;
		begin
			src_base = 8'hC0;
			run(1'b0, 10'h003, 1'b1);
			chk(to, 10'h000);
			chk(rx_n, 10'h003);
			sent(1'b0, 10'h003);
		end
	endtask
	task t_pair;
		begin
			src_base = 8'h50;
			run(1'b1, 10'h002, 1'b1);
			sent(1'b1, 10'h002);
			run(1'b0, 10'h001, 1'b1);
			chk(rx_n, 10'h001);
			sent(1'b0, 10'h001);
		end
	endtask
	task t_len0;
		begin
			len_in = 10'h000;
			start_in = 1'b1;
			@(posedge clk_in) #1;
			start_in = 1'b0;
			repeat (3) @(posedge clk_in) #1;
			chk(busy_out, 10'h000);
			chk(cs_n_out, 10'h003);
		end
	endtask
	task t_reset;
		begin
			dev_sel_in = 1'b1;
			len_in = 10'h002;
			tx_valid_in = 1'b1;
			start_in = 1'b1;
			@(posedge clk_in) #1;
			start_in = 1'b0;
			repeat (150) @(posedge clk_in) #1;
			resetn_in = 1'b0;
			repeat (2) @(posedge clk_in) #1;
			resetn_in = 1'b1;
			chk(cs_n_out, 10'h003);
			chk(sck_out, 10'h001);
			chk(busy_out, 10'h000);
			chk(mosi, 10'h001);
		end
	endtask
	task t_stall;
		begin
			run(1'b0, 10'h002, 1'b0);
			chk(to, 10'h001);
			chk(rx_n, 10'h000);
		end
	endtask
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	initial begin
		#500000;
		err_count = err_count + 1;
		test_done;
	end
	initial begin
		{resetn_in, start_in, dev_sel_in, tx_valid_in, to} = 5'h00;
		{len_in, src_base, exp_base} = 26'h0;
		{err_count, check_count, rx_n} = 0;
		repeat (20) @(posedge clk_in);
		#1 resetn_in = 1'b1;
		t_frame;
		t_pair;
		t_len0;
		t_reset;
		t_stall;
		test_done;
	end
endmodule
